// File: logic/hsdsp_chain.sv
/*
 Digital path of the magnetic sensor: sample pacing, temperature
 compensation, fine gain and offset, piecewise linearization, polarity,
 clamps and a result FIFO feeding the PWM or SENT encoder.
 Assumes the converter, temperature sensor and settings store run on the
 same clock, and that the encoder drains the FIFO with valid/ready.
*/
`timescale 1ns/100ps

module hsdsp_fifo #(
   parameter int W = 13,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         clk_en_in,
   // filling side
   input  wire logic         in_valid_in,
   input  wire logic [W-1:0] in_data_in,
   output logic              in_ready_out,
   // draining side
   output logic              out_valid_out,
   output logic [W-1:0]      out_data_out,
   input  wire logic         out_ready_in
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0]         cnt;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
   } hsdsp_fifo_st_t;

   hsdsp_fifo_st_t s_r;
   hsdsp_fifo_st_t s_nxt;
   logic           push;
   logic           pop;

   // honest full and empty straight from the occupancy count
   assign in_ready_out  = (s_r.cnt != (AW+1)'(D));
   assign out_valid_out = (s_r.cnt != '0);
   assign out_data_out  = s_r.mem[s_r.rp];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // pointer and storage update
   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = in_data_in;
         s_nxt.wp          = s_r.wp + AW'(1);
      end
      if (pop)
      begin
         s_nxt.rp = s_r.rp + AW'(1);
      end
      if (push && !pop)
      begin
         s_nxt.cnt = s_r.cnt + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         s_nxt.cnt = s_r.cnt - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s_r <= '0;
      end
      else if (clk_en_in)
      begin
         s_r <= s_nxt;
      end
   end

endmodule : hsdsp_fifo

module hsdsp_chain
   import hsdsp_pkg::*;
#(
   parameter int DIV_LO_P = hsdsp_pkg::DIV_LO,
   parameter int LAT_LO_P = hsdsp_pkg::LAT_LO
) (
   // clock, reset and freeze
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  clk_en_in,
   // converter and temperature sensor
   input  wire logic [11:0]           adc_sample_in,
   input  wire logic signed [8:0]     ambient_temp_in,
   // stored settings
   input  wire logic [1:0]            bandwidth_select_in,
   input  wire logic [3:0]            coarse_range_in,
   input  wire hsdsp_pkg::hsdsp_tc_t  tc_coeff_in,
   input  wire logic [11:0]           fine_gain_code_in,
   input  wire logic signed [11:0]    fine_offset_code_in,
   input  wire hsdsp_pkg::hsdsp_lut_t lin_coeff_in,
   input  wire hsdsp_pkg::hsdsp_outcfg_t out_cfg_in,
   // diagnostic override
   input  wire logic                  diag_force_in,
   input  wire logic [11:0]           diag_level_in,
   // encoder side
   output logic                       enc_valid_out,
   output hsdsp_pkg::hsdsp_word_t     enc_word_out,
   input  wire logic                  enc_ready_in,
   output logic                       sample_tick_out,
   output logic                       emit_stall_out
);
   import hsdsp_pkg::*;

   typedef struct packed {
      logic [15:0]                 tcnt;
      logic [11:0]                 smp;
      logic                        v0;
      logic signed [11:0]          comp;
      logic                        v1;
      logic signed [11:0]          trim;
      logic                        v2;
      logic [11:0]                 res;
      logic [LAT_TICKS-1:0][11:0]  dly;
      logic [2:0]                  dcnt;
      hsdsp_word_t                 emit;
      logic                        pend;
      logic                        tick;
   } hsdsp_st_t;

   hsdsp_st_t          s_r;
   hsdsp_st_t          s_nxt;
   logic               fifo_ready;
   logic [15:0]        div;
   logic [15:0]        off;
   logic signed [9:0]  dt;
   logic signed [7:0]  c1;
   logic signed [7:0]  c2;
   logic signed [31:0] gadj;
   logic signed [31:0] drift;
   logic signed [47:0] acc;
   logic signed [11:0] x;
   logic signed [11:0] li;
   logic signed [11:0] lo;
   logic signed [11:0] a;
   logic signed [11:0] b;
   logic signed [23:0] step;
   logic [11:0]        u;
   logic [11:0]        uo;
   logic [4:0]         idx;

   // limit a wide signed result to the 12-bit signed range
   function automatic logic signed [11:0] sat12(input logic signed [47:0] v);
      logic signed [11:0] r;
      if (v > 48'(SAT_MAX))
      begin
         r = SAT_MAX;
      end
      else if (v < 48'(SAT_MIN))
      begin
         r = SAT_MIN;
      end
      else
      begin
         r = v[11:0];
      end
      return r;
   endfunction : sat12

   // pace and latency offset for the chosen bandwidth
   always_comb
   begin
      if (bandwidth_select_in == BW_LO)
      begin
         div = 16'(DIV_LO_P); // R01
         off = 16'(LAT_LO_P - LAT_TICKS * DIV_LO_P); // R02
      end
      else if (bandwidth_select_in == BW_MID)
      begin
         div = 16'(DIV_MID); // R01
         off = 16'(LAT_MID - LAT_TICKS * DIV_MID); // R02
      end
      else
      begin
         div = 16'(DIV_HI); // R01
         off = 16'(LAT_HI - LAT_TICKS * DIV_HI); // R02
      end
   end

   // temperature delta and segment coefficient choice
   always_comb
   begin
      dt = 10'(ambient_temp_in) - T_REF_C; // R08
      if (dt > 10'sh000)
      begin
         c1 = tc_coeff_in.first_order_hot_coeff; // R05
         c2 = tc_coeff_in.second_order_hot_coeff; // R05
      end
      else
      begin
         c1 = tc_coeff_in.first_order_cold_coeff; // R05
         c2 = tc_coeff_in.second_order_cold_coeff; // R05
      end
      // a zero coefficient simply drops its own order out of the sum
      gadj = ((32'(c1) * 32'(dt)) <<< TC1_SHIFT) + 32'(c2) * 32'(dt) * 32'(dt); // R06
      // coarse code 0 is the 0.1%/G range; each code step doubles drift step
      drift = ((32'(tc_coeff_in.offset_drift_coeff) * 32'(dt)) <<< coarse_range_in) >>> DRIFT_FRAC; // R03 R04 R20
   end

   // linearization input, segment and interpolation
   always_comb
   begin
      li   = out_cfg_in.lin_input_invert ? ~s_r.trim : s_r.trim; // R14
      u    = {~li[11], li[10:0]};
      idx  = u[11:7]; // R12
      a    = $signed(lin_coeff_in[idx]); // R13
      b    = $signed(lin_coeff_in[6'(idx) + 6'h01]); // R13
      step = (24'(b) - 24'(a)) * 24'($signed({1'b0, u[6:0]}));
      // interpolation stays between two 12-bit points, so no overflow
      lo   = 12'(24'(a) + (step >>> LIN_FRAC)); // R12
   end

   // main datapath and emission control
   always_comb
   begin
      s_nxt      = s_r;
      x          = $signed({~s_r.smp[11], s_r.smp[10:0]});
      acc        = '0;
      uo         = '0;
      s_nxt.tick = 1'b0;
      s_nxt.v0   = 1'b0;
      s_nxt.v1   = 1'b0;
      s_nxt.v2   = 1'b0;

      // update tick; a bandwidth change mid-count wraps safely
      if (s_r.tcnt >= div - 16'h0001)
      begin
         s_nxt.tcnt = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.tcnt = s_r.tcnt + 16'h0001;
      end

      // take a fresh converter word once per tick
      if (s_r.tick)
      begin
         s_nxt.smp = adc_sample_in; // R21 R01
         s_nxt.v0  = 1'b1; // R22
      end

      // stage one: sensitivity and offset temperature compensation
      if (s_r.v0)
      begin
         acc        = 48'(x) + ((48'(x) * 48'(gadj)) >>> GAIN_FRAC) + 48'(drift); // R07 R03
         s_nxt.comp = sat12(acc); // R23
         s_nxt.v1   = 1'b1; // R22
      end

      // stage two: fine gain then fine offset, ahead of linearization
      if (s_r.v1)
      begin
         acc = (48'(s_r.comp) * 48'($signed({1'b0, ~fine_gain_code_in[11], fine_gain_code_in[10:0]})))
               >>> FG_FRAC; // R09 R10
         acc        = acc + 48'(fine_offset_code_in); // R11 R10 R19
         s_nxt.trim = sat12(acc); // R23
         s_nxt.v2   = 1'b1; // R22
      end

      // stage three: polarity, resolution, clamps or diagnostic level
      if (s_r.v2)
      begin
         uo = out_cfg_in.output_invert ? {lo[11], ~lo[10:0]} : {~lo[11], lo[10:0]}; // R15
         if (bandwidth_select_in != BW_LO && bandwidth_select_in != BW_MID)
         begin
            uo[0] = 1'b0; // R02
         end
         if (diag_force_in)
         begin
            s_nxt.res = diag_level_in; // R17
         end
         else if (uo < out_cfg_in.clamp_low)
         begin
            s_nxt.res = out_cfg_in.clamp_low; // R16 R19
         end
         else if (uo > out_cfg_in.clamp_high)
         begin
            s_nxt.res = out_cfg_in.clamp_high; // R16 R19
         end
         else
         begin
            s_nxt.res = uo;
         end
      end

      // latency line advances one slot per tick
      if (s_r.tick)
      begin
         for (int i = LAT_TICKS - 1; i > 0; i--)
         begin
            s_nxt.dly[i] = s_r.dly[i-1];
         end
         s_nxt.dly[0] = s_r.res;
         if (s_r.dcnt != 3'(LAT_TICKS))
         begin
            s_nxt.dcnt = s_r.dcnt + 3'h1;
         end
      end

      // handed word clears on acceptance; a new emission wins
      if (s_r.pend && fifo_ready)
      begin
         s_nxt.pend = 1'b0;
      end
      if (s_r.tcnt == off && s_r.dcnt == 3'(LAT_TICKS))
      begin
         s_nxt.emit.level      = s_r.dly[LAT_TICKS-1]; // R02
         s_nxt.emit.pwm_format = out_cfg_in.pwm_format; // R18
         s_nxt.pend            = 1'b1; // R22
      end
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         s_r <= '0;
      end
      else if (clk_en_in)
      begin
         s_r <= s_nxt;
      end
   end

   // result buffer toward the encoder; full holds the pending word until the next emission replaces it
   hsdsp_fifo #(
      .W ($bits(hsdsp_word_t)),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .clk_en_in     (clk_en_in),
      .in_valid_in   (s_r.pend),
      .in_data_in    (s_r.emit),
      .in_ready_out  (fifo_ready),
      .out_valid_out (enc_valid_out),
      .out_data_out  (enc_word_out),
      .out_ready_in  (enc_ready_in)
   );

   assign sample_tick_out = s_r.tick;
   assign emit_stall_out  = s_r.pend && !fifo_ready;

endmodule : hsdsp_chain

// File: logic/hsdsp_pkg.sv
/*
 Shared constants and carrier types for the magnetic sensor signal chain:
 update rates, path latency, arithmetic scaling, clamp defaults and the
 packed structs that carry coefficient sets and encoder words.
 Assumes a single 10 MHz core clock and settings held stable by the
 configuration store outside this block.
*/
// How it works
// [R01] samples taken at 2, 8 or 16 kHz
// [R02] path latency 2.8, 0.7 or 0.35 ms
// [R03] add drift coefficient times temperature delta
// [R04] drift step scales with coarse range code
// [R05] hot coefficients above 25C, cold below
// [R06] first and second order act independently
// [R07] sample plus sample times gain correction, plus drift
// [R08] delta is temperature minus 25C, signed
// [R09] gain code 0=1x, 2047=2x, 2048=~0x
// [R10] trimmed value is gain times value plus offset
// [R11] fine offset signed, up to half scale
// [R12] 33 points, 32 equal interpolation segments
// [R13] points are 12-bit two's complement
// [R14] input inversion flips linearization input
// [R15] output inversion flips output polarity
// [R16] clamp normal output, defaults 0% and 100%
// [R17] diagnostic levels bypass the clamps
// [R18] format bit selects PWM or SENT
// [R19] gain/offset before linearization, clamps after
// [R20] coarse code zero means 0.1% per gauss
// [R21] converter samples are 12 bits
// [R22] one sample per tick with valid strobe
// [R23] arithmetic saturates instead of wrapping
package hsdsp_pkg;

   // core clock and internal update rates
   localparam int  CLK_HZ       = 10_000_000;
   localparam real RATE_LO_KHZ  = 2.0;
   localparam real RATE_MID_KHZ = 8.0;
   localparam real RATE_HI_KHZ  = 16.0;
   localparam int  DIV_LO  = int'(CLK_HZ / (RATE_LO_KHZ * 1000.0));
   localparam int  DIV_MID = int'(CLK_HZ / (RATE_MID_KHZ * 1000.0));
   localparam int  DIV_HI  = int'(CLK_HZ / (RATE_HI_KHZ * 1000.0));

   // input to output latency per bandwidth setting
   localparam real LAT_LO_MS  = 2.8;
   localparam real LAT_MID_MS = 0.7;
   localparam real LAT_HI_MS  = 0.35;
   localparam int  LAT_LO  = int'(LAT_LO_MS * CLK_HZ / 1000.0);
   localparam int  LAT_MID = int'(LAT_MID_MS * CLK_HZ / 1000.0);
   localparam int  LAT_HI  = int'(LAT_HI_MS * CLK_HZ / 1000.0);
   localparam int  LAT_TICKS = 5;

   // bandwidth select codes
   localparam logic [1:0] BW_LO  = 2'h0;
   localparam logic [1:0] BW_MID = 2'h1;

   // data widths and arithmetic scaling
   localparam int ADC_W      = 12;
   localparam int LUT_N      = 33;
   localparam int FIFO_DEPTH = 16;
   localparam int TC1_SHIFT  = 4;
   localparam int GAIN_FRAC  = 20;
   localparam int DRIFT_FRAC = 6;
   localparam int FG_FRAC    = 11;
   localparam int LIN_FRAC   = 7;
   localparam logic signed [9:0]  T_REF_C = 10'sh019;
   localparam logic signed [11:0] SAT_MAX = 12'sh7FF;
   localparam logic signed [11:0] SAT_MIN = 12'sh800;

   // clamp defaults the configuration store loads at power-up
   localparam logic [11:0] CLAMP_LO_DEF = 12'h000;
   localparam logic [11:0] CLAMP_HI_DEF = 12'hFFF;

   // temperature coefficient set
   typedef struct packed {
      logic signed [7:0] first_order_hot_coeff;
      logic signed [7:0] first_order_cold_coeff;
      logic signed [7:0] second_order_hot_coeff;
      logic signed [7:0] second_order_cold_coeff;
      logic signed [7:0] offset_drift_coeff;
   } hsdsp_tc_t;

   // output shaping settings
   typedef struct packed {
      logic        lin_input_invert;
      logic        output_invert;
      logic        pwm_format;
      logic [11:0] clamp_low;
      logic [11:0] clamp_high;
   } hsdsp_outcfg_t;

   typedef logic [LUT_N-1:0][11:0] hsdsp_lut_t;

   // word handed to the output encoder
   typedef struct packed {
      logic        pwm_format;
      logic [11:0] level;
   } hsdsp_word_t;

endpackage : hsdsp_pkg

// File: verif/hsdsp_chain_chk.sv
/*
 Concurrent checks on the sensor chain ports: tick pacing, latency, FIFO hold.
 Assumes clk_en_in stays high whenever the checks matter.
*/
`timescale 1ns/100ps

module hsdsp_chain_chk #(
   parameter int DIV_LO_P = hsdsp_pkg::DIV_LO,
   parameter int LAT_LO_P = hsdsp_pkg::LAT_LO
) (
   input wire logic                   clk_in,
   input wire logic                   reset_in,
   input wire logic [1:0]             bandwidth_select_in,
   input wire logic                   enc_valid_out,
   input wire hsdsp_pkg::hsdsp_word_t enc_word_out,
   input wire logic                   enc_ready_in,
   input wire logic                   sample_tick_out,
   input wire logic                   emit_stall_out
);
   import hsdsp_pkg::*;
   logic [15:0] gap_r;
   logic [15:0] cyc_r;
   logic        seen_r;
   logic [1:0]  bw_r;
   int          exp_gap;
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // tick period per rate code; a bandwidth change voids one gap
   assign exp_gap = (bw_r == 2'h0) ? DIV_LO_P : (bw_r == 2'h1) ? DIV_MID : DIV_HI;
   // gap counter, cycle count since reset (saturating so it never wraps)
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         gap_r  <= 16'h0000;
         cyc_r  <= 16'h0000;
         seen_r <= 1'b0;
         bw_r   <= 2'h0;
      end
      else
      begin
         gap_r  <= sample_tick_out ? 16'h0000 : gap_r + 16'h0001;
         cyc_r  <= (cyc_r == 16'hFFFF) ? cyc_r : cyc_r + 16'h0001;
         seen_r <= sample_tick_out ? 1'b1 : (bandwidth_select_in != bw_r) ? 1'b0 : seen_r;
         bw_r   <= bandwidth_select_in;
      end
   end
   tick_gap_a: assert property (sample_tick_out && seen_r && bandwidth_select_in == bw_r |->
      gap_r == 16'(exp_gap - 1)) else $error("tick spacing off");
   tick_pulse_a: assert property (sample_tick_out |=> !sample_tick_out [*8])
      else $error("tick not a lone pulse");
   reset_quiet_a: assert property ($fell(reset_in) |-> (!sample_tick_out && !enc_valid_out) [*3])
      else $error("activity right after reset");
   first_out_a: assert property (enc_valid_out |-> cyc_r >= 16'(LAT_LO_P))
      else $error("result earlier than path latency");
   valid_hold_a: assert property (enc_valid_out && !enc_ready_in |=> enc_valid_out && $stable(enc_word_out))
      else $error("unaccepted word changed");
   stall_full_a: assert property (emit_stall_out |-> enc_valid_out)
      else $error("stall with empty fifo");
   stall_hold_a: assert property (emit_stall_out && !enc_ready_in |=> enc_valid_out)
      else $error("word lost during stall");
   hi_gap_a: assert property (sample_tick_out && seen_r && bw_r == 2'h2 && bandwidth_select_in == bw_r |->
      gap_r == 16'(DIV_HI - 1)) else $error("fast rate tick spacing off");
   tick_c: cover property (sample_tick_out);
   stall_c: cover property (emit_stall_out);
   pop_c: cover property (enc_valid_out && enc_ready_in);
endmodule : hsdsp_chain_chk

bind hsdsp_chain hsdsp_chain_chk #(.DIV_LO_P(DIV_LO_P), .LAT_LO_P(LAT_LO_P)) chk (
   .clk_in(clk_in), .reset_in(reset_in), .bandwidth_select_in(bandwidth_select_in),
   .enc_valid_out(enc_valid_out), .enc_word_out(enc_word_out), .enc_ready_in(enc_ready_in),
   .sample_tick_out(sample_tick_out), .emit_stall_out(emit_stall_out));

// File: verif/hsdsp_enc_model.sv
/*
 Behavioural output encoder: pops result words, keeps the last one and a count.
 Assumes the bench raises hold_in to make it stall like a busy encoder.
*/
`timescale 1ns/100ps

module hsdsp_enc_model (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   // chain side
   input  wire logic                   valid_in,
   input  wire hsdsp_pkg::hsdsp_word_t word_in,
   output logic                        ready_out,
   // bench side
   input  wire logic                   hold_in,
   output hsdsp_pkg::hsdsp_word_t      last_out,
   output logic [15:0]                 pops_out
);
   import hsdsp_pkg::*;
   // ready follows hold one edge late, as a real encoder frame would
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ready_out <= 1'b0;
         last_out  <= '0;
         pops_out  <= 16'h0000;
      end
      else
      begin
         ready_out <= !hold_in;
         if (valid_in && ready_out)
         begin
            last_out <= word_in;
            pops_out <= pops_out + 16'h0001;
         end
      end
   end
endmodule : hsdsp_enc_model

// File: verif/tb_top.sv
/*
 Self-checking bench for the sensor chain with a short low-rate divider.
 Assumes the encoder model drains results; settings change between runs only.
*/
`timescale 1ns/100ps

module tb_top;
   import hsdsp_pkg::*;
   localparam int DIV = 50;
   localparam int LAT = 280;
   logic clk = 0, reset_in = 1, hold = 0, ready, valid, tick, stall;
   logic [11:0] adc = 12'h800, gain = 12'h000, offs = 12'h000, dlev = 12'hFFF;
   logic [1:0] bw = 2'h0;
   logic [3:0] rng = 4'h0;
   logic signed [8:0] temp = 9'sd25;
   hsdsp_tc_t tc = '0;
   hsdsp_lut_t lut;
   hsdsp_outcfg_t cfg = '0;
   logic diag = 0;
   hsdsp_word_t word, last;
   logic [15:0] pops;
   int errors = 0, check_count = 0, cyc = 0;

   hsdsp_chain #(.DIV_LO_P(DIV), .LAT_LO_P(LAT)) dut (.clk_in(clk), .reset_in(reset_in),
      .clk_en_in(1'b1), .adc_sample_in(adc), .ambient_temp_in(temp), .bandwidth_select_in(bw),
      .coarse_range_in(rng), .tc_coeff_in(tc), .fine_gain_code_in(gain), .fine_offset_code_in(offs),
      .lin_coeff_in(lut), .out_cfg_in(cfg), .diag_force_in(diag), .diag_level_in(dlev),
      .enc_valid_out(valid), .enc_word_out(word), .enc_ready_in(ready),
      .sample_tick_out(tick), .emit_stall_out(stall));
   hsdsp_enc_model enc (.clk_in(clk), .reset_in(reset_in), .valid_in(valid), .word_in(word),
      .ready_out(ready), .hold_in(hold), .last_out(last), .pops_out(pops));

   // free-running clock and hang guard
   initial forever #50 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : step

   // tick spacing for each rate code, sampled off the edge so no race with the pulse
   task automatic t_rate(input logic [1:0] code, input int per);
      int n;
      bw = code;
      @(posedge tick);
      @(posedge tick);
      #5;
      n = 0;
      do
      begin
         step(1);
         n++;
      end
      while (tick !== 1'b1);
      chk(16'(n), 16'(per));
   endtask : t_rate

   // apply settings, let the pipeline flush, judge the last popped word and the pace
   task automatic run(input logic [11:0] g, o, ch, a, input logic [3:0] f, input logic [12:0] e);
      logic [15:0] p;
      gain = g;
      offs = o;
      adc = a;
      diag = f[2];
      cfg = '{f[1], f[3], f[0], CLAMP_LO_DEF, ch};
      p = pops;
      step(10 * DIV);
      chk({3'h0, last}, {3'h0, e});
      chk(pops - p, 16'h000A);
   endtask : run

   // coefficient set, temperature and coarse range for one compensation case
   task automatic t_temp(input logic signed [8:0] t, input hsdsp_tc_t c, input logic [3:0] r,
                         input logic [12:0] e);
      tc = c;
      temp = t;
      rng = r;
      run(12'h000, 12'h000, 12'hFFF, 12'hA00, 4'h0, e);
      tc = '0;
      temp = 9'sd25;
      rng = 4'h0;
   endtask : t_temp

   // latency at the low rate: one edge to capture, then pend to fifo and fifo to pop
   task automatic t_lat();
      int n;
      @(posedge tick);
      #5;
      adc = 12'h900;
      n = 0;
      while (last !== 13'h0900)
      begin
         step(1);
         n++;
      end
      chk(16'(n), 16'(LAT + 3));
      adc = 12'hA00;
   endtask : t_lat

   // encoder stalls until the fifo refuses, then drains
   task automatic t_stall();
      hold = 1;
      step(20 * DIV);
      chk({15'h0, stall}, 16'h0001);
      hold = 0;
      step(2 * DIV);
      chk({15'h0, stall}, 16'h0000);
      chk({3'h0, last}, 16'h0A00);
   endtask : t_stall

   initial
   begin
      for (int k = 0; k < 33; k++)
         lut[k] = (k == 32) ? 12'h7FF : (12'(k) << 7) ^ 12'h800;
      step(8);
      reset_in = 0;
      t_rate(2'h1, DIV_MID);
      t_rate(2'h2, DIV_HI);
      t_rate(2'h0, DIV);
      run(12'h000, 12'h000, 12'hFFF, 12'hA00, 4'h1, 13'h1A00);
      run(12'h000, 12'h000, 12'hFFF, 12'hA00, 4'h0, 13'h0A00);
      run(12'h7FF, 12'h000, 12'hFFF, 12'hA00, 4'h0, 13'h0BFF);
      run(12'h800, 12'h000, 12'hFFF, 12'hA00, 4'h0, 13'h0800);
      run(12'h000, 12'h100, 12'hFFF, 12'hA00, 4'h0, 13'h0B00);
      run(12'h000, 12'hF00, 12'hFFF, 12'hA00, 4'h0, 13'h0900);
      run(12'h000, 12'h000, 12'h900, 12'hA00, 4'h0, 13'h0900);
      run(12'h000, 12'h000, 12'h900, 12'hA00, 4'h4, 13'h0FFF);
      run(12'h000, 12'h000, 12'hFFF, 12'hA00, 4'h2, 13'h05FF);
      run(12'h000, 12'h000, 12'hFFF, 12'hA00, 4'h8, 13'h05FF);
      run(12'h7FF, 12'h7FF, 12'hFFF, 12'hA00, 4'h0, 13'h0FFE);
      t_temp(9'sh07D, {8'h40, 8'hC0, 24'h000000}, 4'h0, 13'h0A32);
      t_temp(-9'sh04B, {8'h40, 8'hC0, 24'h000000}, 4'h0, 13'h0A32);
      t_temp(9'sh07D, {16'h0000, 8'h01, 16'h0000}, 4'h0, 13'h0A04);
      t_temp(9'sh07D, {8'h40, 8'h00, 8'h01, 16'h0000}, 4'h0, 13'h0A36);
      t_temp(9'sh07D, {32'h00000000, 8'h10}, 4'h0, 13'h0A19);
      t_temp(9'sh07D, {32'h00000000, 8'h10}, 4'h1, 13'h0A32);
      t_lat();
      t_stall();
      stop_test();
   end
endmodule : tb_top
